// *** src/mic_pkg.sv ***
package mic_pkg;

  // core timing: one machine cycle is four core clocks
  localparam int MC_CLKS  = 4;
  localparam int NUM_SRC  = 13;
  localparam int NUM_FLAG = 14;

  // source index equals arbitration rank, 0 ranks highest
  localparam int SRC_EXT_A   = 0;
  localparam int SRC_BROWN   = 1;
  localparam int SRC_WDOG    = 2;
  localparam int SRC_TMR_A   = 3;
  localparam int SRC_I2C     = 4;
  localparam int SRC_CONV    = 5;
  localparam int SRC_EXT_B   = 6;
  localparam int SRC_KEYB    = 7;
  localparam int SRC_CMP_A   = 8;
  localparam int SRC_TMR_B   = 9;
  localparam int SRC_CMP_B   = 10;
  localparam int SRC_SERIAL  = 11;
  localparam int SRC_PWM     = 12;

  // flag bits follow source index; serial receive uses the serial slot
  localparam int FLAG_SER_TX = 13;

  // enable and priority layout
  localparam int PRIM_EN_W = 7;
  localparam int EXT_EN_W  = 6;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int WDOG_EN_BIT   = 4;

  // bit of {extended_enable_reg, primary_enable_reg[6:0]} per source
  localparam logic [NUM_SRC-1:0][3:0] SRC_BIT = {
    4'hC, 4'h4, 4'hA, 4'h3, 4'h9, 4'h8, 4'h2,
    4'h6, 4'h7, 4'h1, 4'hB, 4'h5, 4'h0};

  // vector per source
  localparam logic [NUM_SRC-1:0][15:0] SRC_VEC = {
    16'h0073, 16'h0023, 16'h0043, 16'h001B, 16'h0063, 16'h003B, 16'h0013,
    16'h005B, 16'h0033, 16'h000B, 16'h0053, 16'h002B, 16'h0003};

  localparam logic [NUM_FLAG-1:0] FLAG_RST   = 14'h0000;
  localparam logic [3:0]          ACTIVE_RST = 4'h0;

  typedef struct packed {
    logic timer_a_ovf;
    logic timer_b_ovf;
    logic watchdog_timeout;
    logic serial_rx_done;
    logic serial_tx_done;
    logic conversion_done;
    logic comparator_a_toggle;
    logic comparator_b_toggle;
    logic i2c_status_new;
    logic pwm_brake;
    logic brownout_detect;
    logic keyboard_event;
  } mic_hw_evt_t;

  typedef struct packed {
    logic last_mc;
    logic is_return_from_service_op;
    logic writes_en_pri;
    logic return_from_service_op_done;
  } mic_seq_t;

  typedef struct packed {
    logic [15:0] vector;
    logic [3:0]  src;
    logic [1:0]  level;
  } mic_call_t;

  typedef struct packed {
    logic       any;
    logic [1:0] level;
  } mic_lvl_t;

  typedef struct packed {
    logic       found;
    logic [3:0] idx;
    logic [1:0] level;
  } mic_win_t;

endpackage

// *** src/mic_ext_pin.sv ***
`timescale 1ns/1ps

module mic_ext_pin (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin,
  input  wire logic mc_tick,
  output logic      fall,
  output logic      level_low
);

  logic sync1_r;
  logic sync2_r;
  logic sample_r;

  // pin is asynchronous: two flops before the machine-cycle sampler
  always_ff @(posedge clk) begin
    if (srst) begin
      // reset to the pin's idle high level so no false fall follows reset
      sync1_r  <= 1'b1;
      sync2_r  <= 1'b1;
      sample_r <= 1'b1;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
      if (mc_tick) begin
        sample_r <= sync2_r;
      end
    end
  end

  // high in one machine cycle, low in the next [R02]
  assign fall      = mc_tick & sample_r & ~sync2_r;
  // pulses narrower than a machine cycle may be missed [R03]
  assign level_low = ~sample_r;

endmodule

// *** src/mic_intc.sv ***
`timescale 1ns/1ps

// Summary of operation
// R01: thirteen sources, four levels; each has flag, enable, priority, vector; global gate.
// R02: edge mode samples pins per machine cycle; high then low sets flag.
// R03: external requester holds pin high and low one machine cycle each.
// R04: edge mode pin flag clears automatically when vectoring.
// R05: level mode requester holds pin low until serviced.
// R06: level mode flag follows pin, not cleared on entry.
// R07: timer overflow sets flag; vectoring to the timer clears it.
// R08: watchdog timeout sets flag; needs watchdog enable; software clears only.
// R09: serial receive and transmit flags; software clears only.
// R10: software can set and clear every flag, raising real requests.
// R11: per-source enables plus global enable; global off blocks all.
// R12: conversion done sets its flag; software clears.
// R13: each comparator toggle sets its own flag; software clears.
// R14: i2c status sets flag; needs own and global enable.
// R15: pwm brake sets flag; software clears.
// R16: flags sampled, polled and prioritised every machine cycle.
// R17: call only on last machine cycle, no equal or higher level active.
// R18: no call during return-from-service or enable/priority writes.
// R19: pending requests are not remembered between polls.
// R20: call pushes pc like long call, keeps status word, loads vector.
// R21: priority from high and low bits; only strictly higher preempts.
// R22: same-level ties resolved by fixed rank, pin a highest, brake lowest.
// R23: return-from-service ends the active level; plain return does not.
// R24: vectors eight bytes apart from 0003h up to 0073h.
module mic_intc
  import mic_pkg::*;
#(
  parameter int MC_CLKS_P = MC_CLKS
) (
  input  wire logic              CLK,
  input  wire logic              SRST,
  input  wire logic              EXT_REQUEST_PIN_A,
  input  wire logic              EXT_REQUEST_PIN_B,
  input  wire logic [1:0]        EXT_TRIGGER_SELECT,
  input  wire mic_hw_evt_t       HW_EVENT,
  input  wire logic [NUM_FLAG-1:0] SW_FLAG_SET,
  input  wire logic [NUM_FLAG-1:0] SW_FLAG_CLR,
  input  wire logic [7:0]        PRIMARY_ENABLE_REG,
  input  wire logic [5:0]        EXTENDED_ENABLE_REG,
  input  wire logic [6:0]        PRIORITY_LOW_REG_A,
  input  wire logic [6:0]        PRIORITY_HIGH_REG_A,
  input  wire logic [5:0]        PRIORITY_LOW_REG_B,
  input  wire logic [5:0]        PRIORITY_HIGH_REG_B,
  input  wire mic_seq_t          SEQ_STATUS,
  output logic                   CALL_STB,
  output mic_call_t              CALL_INFO,
  output logic [NUM_FLAG-1:0]    REQUEST_FLAGS,
  output logic [3:0]             ACTIVE_LEVELS,
  output logic                   MC_TICK
);

  localparam int          MC_W    = (MC_CLKS_P > 1) ? $clog2(MC_CLKS_P) : 1;
  localparam logic [MC_W-1:0] MC_LAST = MC_W'(MC_CLKS_P - 1);

  // highest-level pending source, lowest rank index on ties
  function automatic mic_win_t pick_src(
    input logic [NUM_SRC-1:0]      pend,
    input logic [NUM_SRC-1:0][1:0] lvl
  );
    mic_win_t w;
    w = '0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (pend[i] && (!w.found || lvl[i] >= w.level)) begin
        w.found = 1'b1;
        w.idx   = 4'(i);
        w.level = lvl[i];
      end
    end
    return w;
  endfunction

  // highest level currently marked in service
  function automatic mic_lvl_t top_level(input logic [3:0] act);
    mic_lvl_t t;
    t = '0;
    for (int l = 0; l < 4; l++) begin
      if (act[l]) begin
        t.any   = 1'b1;
        t.level = 2'(l);
      end
    end
    return t;
  endfunction

  function automatic logic [3:0] level_bit(input logic [1:0] l);
    return 4'h1 << l;
  endfunction

  // machine cycle timing
  logic [MC_W-1:0] mc_cnt_r;
  logic [MC_W-1:0] mc_cnt_nxt;
  logic            mc_tick;

  assign mc_tick    = (mc_cnt_r == MC_LAST);
  assign mc_cnt_nxt = mc_tick ? '0 : mc_cnt_r + MC_W'(1);

  // external pins
  logic [1:0] ext_pin;
  logic [1:0] ext_fall;
  logic [1:0] ext_low;
  logic [1:0] ext_edge_mode;

  assign ext_pin       = {EXT_REQUEST_PIN_B, EXT_REQUEST_PIN_A};
  assign ext_edge_mode = EXT_TRIGGER_SELECT;

  for (genvar g = 0; g < 2; g++) begin : g_ext
    mic_ext_pin u_pin (
      .clk       (CLK),
      .srst      (SRST),
      .pin       (ext_pin[g]),
      .mc_tick   (mc_tick),
      .fall      (ext_fall[g]),
      .level_low (ext_low[g])
    );
  end

  // state
  logic [NUM_FLAG-1:0] flag_r;
  logic [NUM_FLAG-1:0] flag_nxt;
  logic [3:0]          active_r;
  logic [3:0]          active_nxt;
  logic                call_stb_r;
  mic_call_t           call_info_r;
  mic_call_t           call_info_nxt;

  // hardware set events
  logic [NUM_FLAG-1:0] hw_set;

  assign hw_set[SRC_EXT_A]   = ext_edge_mode[0] & ext_fall[0];          // [R02]
  assign hw_set[SRC_EXT_B]   = ext_edge_mode[1] & ext_fall[1];          // [R02]
  assign hw_set[SRC_TMR_A]   = HW_EVENT.timer_a_ovf;                    // [R07]
  assign hw_set[SRC_TMR_B]   = HW_EVENT.timer_b_ovf;                    // [R07]
  assign hw_set[SRC_WDOG]    = HW_EVENT.watchdog_timeout;               // [R08]
  assign hw_set[SRC_SERIAL]  = HW_EVENT.serial_rx_done;                 // [R09]
  assign hw_set[FLAG_SER_TX] = HW_EVENT.serial_tx_done;                 // [R09]
  assign hw_set[SRC_CONV]    = HW_EVENT.conversion_done;                // [R12]
  assign hw_set[SRC_CMP_A]   = HW_EVENT.comparator_a_toggle;            // [R13]
  assign hw_set[SRC_CMP_B]   = HW_EVENT.comparator_b_toggle;            // [R13]
  assign hw_set[SRC_I2C]     = HW_EVENT.i2c_status_new;                 // [R14]
  assign hw_set[SRC_PWM]     = HW_EVENT.pwm_brake;                      // [R15]
  assign hw_set[SRC_BROWN]   = HW_EVENT.brownout_detect;
  assign hw_set[SRC_KEYB]    = HW_EVENT.keyboard_event;

  // source decode
  logic [NUM_SRC-1:0]      src_flag;
  logic [NUM_SRC-1:0]      src_en;
  logic [NUM_SRC-1:0][1:0] src_lvl;
  logic [NUM_SRC-1:0]      src_pend;
  logic [12:0]             en_all;
  logic [12:0]             pri_lo;
  logic [12:0]             pri_hi;
  logic                    global_en;

  assign en_all    = {EXTENDED_ENABLE_REG, PRIMARY_ENABLE_REG[PRIM_EN_W-1:0]};
  assign pri_lo    = {PRIORITY_LOW_REG_B, PRIORITY_LOW_REG_A};
  assign pri_hi    = {PRIORITY_HIGH_REG_B, PRIORITY_HIGH_REG_A};
  assign global_en = PRIMARY_ENABLE_REG[GLOBAL_EN_BIT];

  for (genvar s = 0; s < NUM_SRC; s++) begin : g_src
    if (s == SRC_SERIAL) begin : g_ser
      // receive and transmit share one request
      assign src_flag[s] = flag_r[s] | flag_r[FLAG_SER_TX];             // [R09]
    end else begin : g_one
      assign src_flag[s] = flag_r[s];
    end
    assign src_en[s]  = en_all[SRC_BIT[s]];                             // [R01]
    assign src_lvl[s] = {pri_hi[SRC_BIT[s]], pri_lo[SRC_BIT[s]]};       // [R21]
  end

  // watchdog uses extended enable bit 4, i2c its own bit, all gated [R08] [R14]
  assign src_pend = src_flag & src_en & {NUM_SRC{global_en}};           // [R11]

  // polling and priority resolution, fresh every machine cycle
  mic_win_t win;
  mic_lvl_t cur;
  logic     gate_ok;
  logic     level_ok;
  logic     call_take;

  assign win      = pick_src(src_pend, src_lvl);                        // [R16] [R22]
  assign cur      = top_level(active_r);
  // equal or lower level never preempts a running routine
  assign level_ok = !cur.any || (win.level > cur.level);                // [R17] [R21]
  assign gate_ok  = SEQ_STATUS.last_mc && !SEQ_STATUS.is_return_from_service_op
                    && !SEQ_STATUS.writes_en_pri;                       // [R17] [R18]
  // decided only from this cycle's flags; a denied request leaves no trace
  assign call_take = mc_tick && win.found && level_ok && gate_ok;       // [R19]

  // hardware clear on vectoring
  logic [NUM_FLAG-1:0] hw_clr;

  always_comb begin
    hw_clr = '0;
    if (call_take) begin
      if (win.idx == 4'(SRC_TMR_A)) begin
        hw_clr[SRC_TMR_A] = 1'b1;                                       // [R07]
      end
      if (win.idx == 4'(SRC_TMR_B)) begin
        hw_clr[SRC_TMR_B] = 1'b1;                                       // [R07]
      end
      if (win.idx == 4'(SRC_EXT_A) && ext_edge_mode[0]) begin
        hw_clr[SRC_EXT_A] = 1'b1;                                       // [R04]
      end
      if (win.idx == 4'(SRC_EXT_B) && ext_edge_mode[1]) begin
        hw_clr[SRC_EXT_B] = 1'b1;                                       // [R04]
      end
    end
  end

  // flag update: any set wins over a clear in the same cycle
  always_comb begin
    flag_nxt = (flag_r & ~(SW_FLAG_CLR | hw_clr)) | hw_set | SW_FLAG_SET; // [R10]
    // level mode: flag follows the sampled pin, entry leaves it alone
    if (!ext_edge_mode[0] && mc_tick) begin
      flag_nxt[SRC_EXT_A] = ext_low[0] | SW_FLAG_SET[SRC_EXT_A];        // [R06]
    end
    if (!ext_edge_mode[1] && mc_tick) begin
      flag_nxt[SRC_EXT_B] = ext_low[1] | SW_FLAG_SET[SRC_EXT_B];        // [R06]
    end
  end

  // in-service levels: return-from-service retires the top level
  logic [3:0] return_from_service_op_clr;

  assign return_from_service_op_clr   = (SEQ_STATUS.return_from_service_op_done && cur.any) ? level_bit(cur.level) : 4'h0; // [R23]
  assign active_nxt = (active_r & ~return_from_service_op_clr)
                      | (call_take ? level_bit(win.level) : 4'h0);      // [R17]

  // the sequencer pushes pc as for long_call_op; status word untouched
  always_comb begin
    call_info_nxt = call_info_r;
    if (call_take) begin
      call_info_nxt.vector = SRC_VEC[win.idx];                          // [R20] [R24]
      call_info_nxt.src    = win.idx;
      call_info_nxt.level  = win.level;
    end
  end

  always_ff @(posedge CLK) begin
    if (SRST) begin
      mc_cnt_r    <= '0;
      flag_r      <= FLAG_RST;
      active_r    <= ACTIVE_RST;
      call_stb_r  <= 1'b0;
      call_info_r <= '0;
    end else begin
      mc_cnt_r    <= mc_cnt_nxt;
      flag_r      <= flag_nxt;
      active_r    <= active_nxt;
      call_stb_r  <= call_take;                                         // [R20]
      call_info_r <= call_info_nxt;
    end
  end

  logic mc_tick_r;

  // tick output is delayed one clock to come from a flop
  always_ff @(posedge CLK) begin
    if (SRST) begin
      mc_tick_r <= 1'b0;
    end else begin
      mc_tick_r <= mc_tick;
    end
  end

  assign CALL_STB      = call_stb_r;
  assign CALL_INFO     = call_info_r;
  assign REQUEST_FLAGS = flag_r;
  assign ACTIVE_LEVELS = active_r;
  assign MC_TICK       = mc_tick_r;

endmodule

// *** tb/mic_intc_sva.sv ***
`timescale 1ns/1ps
module mic_intc_chk
  import mic_pkg::*;
#(
  parameter int MC_CLKS_P = MC_CLKS
) (
  input wire logic                CLK,
  input wire logic                SRST,
  input wire mic_hw_evt_t         HW_EVENT,
  input wire logic [NUM_FLAG-1:0] SW_FLAG_SET,
  input wire logic [NUM_FLAG-1:0] SW_FLAG_CLR,
  input wire logic [7:0]          PRIMARY_ENABLE_REG,
  input wire mic_seq_t            SEQ_STATUS,
  input wire logic                CALL_STB,
  input wire mic_call_t           CALL_INFO,
  input wire logic [NUM_FLAG-1:0] REQUEST_FLAGS,
  input wire logic [3:0]          ACTIVE_LEVELS,
  input wire logic                MC_TICK
);
  int   gap_r;
  logic seen_r;
  // first tick after reset has no reference, so seen_r masks it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      gap_r  <= 0;
      seen_r <= 1'b0;
    end else begin
      gap_r  <= MC_TICK ? 0 : gap_r + 1;
      seen_r <= seen_r | MC_TICK;
    end
  end
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (SRST);
  sequence conv_seen;
    HW_EVENT.conversion_done ##1 REQUEST_FLAGS[SRC_CONV];
  endsequence
  tick_period_a: assert property (MC_TICK && seen_r |-> gap_r == MC_CLKS_P - 1)
    else $error("machine cycle length wrong");
  call_on_tick_a: assert property (CALL_STB |-> MC_TICK ##1 !CALL_STB)
    else $error("call off the machine cycle boundary");
  call_gates_a: assert property (CALL_STB |-> $past(SEQ_STATUS.last_mc
    && !SEQ_STATUS.is_return_from_service_op && !SEQ_STATUS.writes_en_pri && PRIMARY_ENABLE_REG[7]))
    else $error("call issued while blocked");
  call_level_a: assert property (CALL_STB && !$past(SEQ_STATUS.return_from_service_op_done)
    |-> ($past(ACTIVE_LEVELS) >> CALL_INFO.level) == 4'h0)
    else $error("call did not outrank active level");
  level_mark_a: assert property (CALL_STB |-> ACTIVE_LEVELS[CALL_INFO.level])
    else $error("active level not marked");
  vector_map_a: assert property (CALL_STB |-> CALL_INFO.vector[2:0] == 3'h3
    && CALL_INFO.vector == SRC_VEC[CALL_INFO.src])
    else $error("vector wrong");
  timer_clear_a: assert property (CALL_STB && CALL_INFO.src == 4'h3
    && !$past(HW_EVENT.timer_a_ovf) && !$past(SW_FLAG_SET[3]) |-> !REQUEST_FLAGS[3])
    else $error("timer flag kept after vectoring");
  serial_keep_a: assert property (CALL_STB && CALL_INFO.src == 4'hB
    && $past(REQUEST_FLAGS[11]) && !$past(SW_FLAG_CLR[11]) |-> REQUEST_FLAGS[11])
    else $error("serial flag cleared by hardware");
  conv_flag_a: assert property (HW_EVENT.conversion_done |-> conv_seen)
    else $error("conversion flag not set");
endmodule
bind mic_intc mic_intc_chk #(.MC_CLKS_P(MC_CLKS_P)) mic_intc_chk_i (.CLK(CLK), .SRST(SRST),
  .HW_EVENT(HW_EVENT), .SW_FLAG_SET(SW_FLAG_SET), .SW_FLAG_CLR(SW_FLAG_CLR),
  .PRIMARY_ENABLE_REG(PRIMARY_ENABLE_REG), .SEQ_STATUS(SEQ_STATUS), .CALL_STB(CALL_STB),
  .CALL_INFO(CALL_INFO), .REQUEST_FLAGS(REQUEST_FLAGS), .ACTIVE_LEVELS(ACTIVE_LEVELS),
  .MC_TICK(MC_TICK));

// *** tb/mic_seq_model.sv ***
`timescale 1ns/1ps
module mic_seq_model
  import mic_pkg::*;
#(
  parameter int RET_DLY = 6
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       call_stb,
  input  wire logic [2:0] gate,
  output mic_seq_t        seq
);
  int   pend_r;
  int   cnt_r;
  logic ret_r;
  // gate: bit0 mid-instruction, bit1 return opcode, bit2 enable/priority write
  assign seq.last_mc       = !gate[0];
  assign seq.is_return_from_service_op       = gate[1];
  assign seq.writes_en_pri = gate[2];
  assign seq.return_from_service_op_done     = ret_r;
  // routines last RET_DLY+2 clocks from call strobe to return pulse; nested calls stack up and return one by one
  always_ff @(posedge clk) begin
    if (srst) begin
      pend_r <= 0;
      cnt_r  <= 0;
      ret_r  <= 1'b0;
    end else begin
      ret_r <= 1'b0;
      cnt_r <= (pend_r == 0 || call_stb) ? 0 : cnt_r + 1;
      if (call_stb) begin
        pend_r <= pend_r + 1;
      end else if (pend_r > 0 && cnt_r >= RET_DLY && !ret_r) begin
        ret_r  <= 1'b1;
        pend_r <= pend_r - 1;
        cnt_r  <= 0;
      end
    end
  end
endmodule

// *** tb/test_mic_intc.sv ***
`timescale 1ns/1ps
module test_mic_intc;
  import mic_pkg::*;
  logic        clk;
  logic        srst;
  logic        pin_a;
  logic        pin_b;
  logic [1:0]  trig;
  mic_hw_evt_t evt;
  logic [13:0] fset;
  logic [13:0] fclr;
  logic [7:0]  pen;
  logic [5:0]  een;
  logic [6:0]  pla;
  logic [6:0]  pha;
  logic [5:0]  plb;
  logic [5:0]  phb;
  logic [2:0]  gate;
  mic_seq_t    seq;
  logic        stb;
  mic_call_t   info;
  logic [13:0] flags;
  logic [3:0]  act;
  int          miscompares;
  int          tests_run;
  logic [15:0] vt [13] = '{16'h0003, 16'h002B, 16'h0053, 16'h000B, 16'h0033, 16'h005B,
    16'h0013, 16'h003B, 16'h0063, 16'h001B, 16'h0043, 16'h0023, 16'h0073};
  int          ev2f [12] = '{3, 9, 2, 11, 13, 5, 8, 10, 4, 12, 1, 7};
  mic_intc #(.MC_CLKS_P(2)) mic_intc_i (.CLK(clk), .SRST(srst), .EXT_REQUEST_PIN_A(pin_a),
    .EXT_REQUEST_PIN_B(pin_b), .EXT_TRIGGER_SELECT(trig), .HW_EVENT(evt), .SW_FLAG_SET(fset),
    .SW_FLAG_CLR(fclr), .PRIMARY_ENABLE_REG(pen), .EXTENDED_ENABLE_REG(een),
    .PRIORITY_LOW_REG_A(pla), .PRIORITY_HIGH_REG_A(pha), .PRIORITY_LOW_REG_B(plb),
    .PRIORITY_HIGH_REG_B(phb), .SEQ_STATUS(seq), .CALL_STB(stb), .CALL_INFO(info),
    .REQUEST_FLAGS(flags), .ACTIVE_LEVELS(act), .MC_TICK());
  mic_seq_model mic_seq_model_i (.clk(clk), .srst(srst), .call_stb(stb), .gate(gate),
    .seq(seq));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    if (miscompares == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_flag(input int i, input logic s);
    if (s) fset[i] = 1'b1;
    else fclr[i] = 1'b1;
    cyc(1);
    fset = '0;
    fclr = '0;
  endtask
  task automatic wait_call(input logic [15:0] v, input logic [1:0] l);
    int n;
    n = 0;
    while (stb !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    if (stb !== 1'b1) begin
      miscompares++;
      give_verdict();
    end
    chk("call vector", v, info.vector);
    chk("call level", {14'h0, l}, {14'h0, info.level});
    chk("active bit", 16'h1, {15'h0, act[l]});
  endtask
  task automatic no_call(input int n);
    repeat (n) begin
      cyc(1);
      chk("no call", 16'h0, {15'h0, stb});
    end
  endtask
  initial begin
    srst = 1'b1;
    {pin_a, pin_b, trig, evt, fset, fclr} = '0;
    {pin_a, pin_b, trig} = 4'hD;
    {pen, een, pla, pha, plb, phb, gate} = {8'hFF, 6'h3F, 29'h0};
    miscompares = 0;
    tests_run = 0;
    repeat (8) @(posedge clk);
    #1;
    srst = 1'b0;
    cyc(1);
    chk("reset flags", 16'h0, {2'h0, flags});
    chk("reset active", 16'h0, {12'h0, act});
    for (int i = 1; i < 14; i++) begin
      if (i != 6) begin
        pulse_flag(i, 1'b1);
        wait_call(vt[i == 13 ? 11 : i], 2'h0);
        chk("flag after call", (i == 3 || i == 9) ? 16'h0 : 16'h1, {15'h0, flags[i]});
        pulse_flag(i, 1'b0);
        cyc(12);
        chk("retired", 16'h0, {12'h0, act});
      end
    end
    pen = 8'h7F;
    for (int k = 0; k < 12; k++) begin
      evt = mic_hw_evt_t'(12'h800 >> k);
      cyc(1);
      evt = '0;
      chk("event flag", 16'h1, {15'h0, flags[ev2f[k]]});
      no_call(4);
      pulse_flag(ev2f[k], 1'b0);
    end
    pen = 8'hFF;
    for (int p = 0; p < 2; p++) begin
      {pla[3], pha[3]} = {2{p[0]}};
      fset = 14'h0208;
      cyc(1);
      fset = '0;
      wait_call(p[0] ? 16'h001B : 16'h000B, p[0] ? 2'h3 : 2'h0);
      no_call(4);
      wait_call(p[0] ? 16'h000B : 16'h001B, 2'h0);
      cyc(16);
    end
    {pla, pha} = '0;
    for (int g = 0; g < 4; g++) begin
      gate = 3'h1 << g;
      pen = (g == 3) ? 8'hBF : 8'hFF;
      pulse_flag(5, 1'b1);
      no_call(6);
      pulse_flag(5, 1'b0);
      {gate, pen} = {3'h0, 8'hFF};
      no_call(6);
    end
    pin_a = 1'b0;
    wait_call(16'h0003, 2'h0);
    chk("edge flag", 16'h0, {15'h0, flags[0]});
    pin_a = 1'b1;
    cyc(16);
    pin_b = 1'b0;
    wait_call(16'h0013, 2'h0);
    chk("level flag", 16'h1, {15'h0, flags[6]});
    cyc(4);
    wait_call(16'h0013, 2'h0);
    pin_b = 1'b1;
    cyc(20);
    chk("idle active", 16'h0, {12'h0, act});
    give_verdict();
  end
endmodule
